// >>> design/cid_cfg.svh
// Constants for the caller ID digital output block.
`ifndef CID_CFG_SVH
`define CID_CFG_SVH
`define CID_CLK_HZ      20000000
`define CID_BAUD        1200
`define CID_HALF_BIT    ((`CID_CLK_HZ) / (2 * (`CID_BAUD)))
`define CID_CHAR_BITS   4'h8
`define CID_BIT_CNT_W   4
`define CID_HALF_CNT_W  16
`define CID_MODE_PACED  1'b0
`define CID_MODE_HOST   1'b1
`define CID_MARK        1'b1
`define CID_SPACE       1'b0
`define CID_BUF_DEPTH   2
`define CID_SCLK_IDLE   1'b1
`endif

// >>> design/cid_pkg.sv
// Types shared by the caller ID digital output block.
`default_nettype none
package cid_pkg;
    typedef logic [7:0] cid_char_t;
    // Sequencer of the device-paced serial clock.
    typedef enum logic [1:0]
    {
        CID_IDLE = 2'b00,
        CID_LOW  = 2'b01,
        CID_HIGH = 2'b10,
        CID_MARK = 2'b11
    } cid_pace_e;
endpackage
`default_nettype wire

// >>> design/cid_buf_if.sv
// Valid/ready carrier for assembled characters between block modules.
`default_nettype none
interface cid_buf_if;
    logic               valid;
    logic               ready;
    cid_pkg::cid_char_t data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> design/cid_buf.sv
// Two-entry character buffer with valid and ready on both sides.
`include "cid_cfg.svh"
`default_nettype none
module cid_buf
(
    // Clock and reset.
    input  wire logic MCLK_IN,
    input  wire logic SYS_RST_IN,
    // Filling and draining sides.
    cid_buf_if.snk    fill,
    cid_buf_if.src    drain
);
    cid_pkg::cid_char_t mem_reg [`CID_BUF_DEPTH];
    logic               wr_ptr_reg;
    logic               rd_ptr_reg;
    logic [1:0]         count_reg;
    wire logic          push;
    wire logic          pop;

    // Full and empty follow the stored count.
    assign fill.ready  = (count_reg != 2'h2);
    assign drain.valid = (count_reg != 2'h0);
    assign drain.data  = mem_reg[rd_ptr_reg];
    assign push        = fill.valid && fill.ready;
    assign pop         = drain.valid && drain.ready;

    // Pointers and count advance on each accepted push and pop.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg  <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage is written without reset; only valid entries are read.
    always_ff @(posedge MCLK_IN)
    begin
        if (push)
            mem_reg[wr_ptr_reg] <= fill.data;
    end
endmodule
`default_nettype wire

// >>> design/cid_out.sv
// Caller ID digital output block: serial data interface, ring and carrier indications.
`include "cid_cfg.svh"
`default_nettype none
module cid_out
#(
    parameter logic [`CID_HALF_CNT_W-1:0] HALF_BIT_CYCLES = `CID_HALF_CNT_W'(`CID_HALF_BIT)
)
(
    // Clock and reset.
    input  wire logic MCLK_IN,
    input  wire logic SYS_RST_IN,
    // Interface mode select pin.
    input  wire logic MODE_SEL_IN,
    // Recovered bit stream from the demodulator.
    input  wire logic FSK_BIT_IN,
    input  wire logic FSK_BIT_VALID_IN,
    input  wire logic FSK_CARRIER_IN,
    output logic      FSK_BIT_READY_OUT,
    // Serial interface pins.
    input  wire logic SERIAL_SHIFT_CLOCK_IN,
    output logic      SERIAL_SHIFT_CLOCK_OUT,
    output logic      SERIAL_SHIFT_CLOCK_OE_OUT,
    output logic      SERIAL_DATA_OUT,
    output logic      CHAR_READY_N_OUT,
    output logic      CARRIER_PRESENT_N_OUT,
    // Ring detection pins.
    input  wire logic RING_SENSE_IN,
    input  wire logic RING_HOLD_TIMING_IN,
    output logic      RING_HOLD_TIMING_OE_OUT,
    output logic      RING_DETECTED_N_OUT
);
    cid_buf_if char_in ();
    cid_buf_if char_out ();

    logic                      mode_s1_reg, mode_reg;
    logic                      sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
    logic                      ring_s1_reg, ring_s2_reg;
    logic                      hold_s1_reg, hold_s2_reg;
    logic [7:0]                asm_reg;
    logic [`CID_BIT_CNT_W-1:0] asm_cnt_reg;
    logic                      asm_full_reg;
    logic [7:0]                shift_reg;
    logic [`CID_BIT_CNT_W-1:0] shift_cnt_reg;
    logic                      shift_busy_reg;
    cid_pkg::cid_pace_e        pace_reg;
    logic [`CID_HALF_CNT_W-1:0] half_cnt_reg;
    logic                      boundary_reg;
    logic                      sclk_out_reg;
    logic                      data_reg;
    logic                      ready_n_reg;
    logic                      carrier_n_reg;
    logic                      ring_n_reg;

    wire logic host_mode;
    wire logic bit_take;
    wire logic last_bit;
    wire logic host_rise;
    wire logic half_done;
    wire logic load_char;

    // Counter wrap test shared by the assembler and the shifter.
    function automatic logic is_last(input logic [`CID_BIT_CNT_W-1:0] cnt);
        is_last = (cnt == (`CID_CHAR_BITS - 4'h1));
    endfunction

    // Mode decode and bit acceptance; the assembler stalls while a char waits.
    assign host_mode         = (mode_reg == `CID_MODE_HOST);
    assign FSK_BIT_READY_OUT = !(host_mode && asm_full_reg);
    assign bit_take          = FSK_BIT_VALID_IN && FSK_BIT_READY_OUT;
    assign last_bit          = is_last(asm_cnt_reg);
    assign host_rise         = sclk_s2_reg && !sclk_s3_reg;
    assign half_done         = (half_cnt_reg == HALF_BIT_CYCLES);
    assign char_in.valid     = asm_full_reg;
    assign char_in.data      = asm_reg;
    assign load_char         = host_mode && !shift_busy_reg && char_out.valid;
    assign char_out.ready    = load_char;

    // Device drives the clock pin only in mode 0.
    assign SERIAL_SHIFT_CLOCK_OE_OUT = !host_mode;
    assign SERIAL_SHIFT_CLOCK_OUT    = sclk_out_reg;
    assign SERIAL_DATA_OUT           = data_reg;
    assign CHAR_READY_N_OUT          = ready_n_reg;
    assign CARRIER_PRESENT_N_OUT     = carrier_n_reg;
    assign RING_DETECTED_N_OUT       = ring_n_reg;
    assign RING_HOLD_TIMING_OE_OUT   = ring_s2_reg; // Discharges the RC while ringing.

    cid_buf u_buf
    (
        .MCLK_IN    (MCLK_IN),
        .SYS_RST_IN (SYS_RST_IN),
        .fill       (char_in.snk),
        .drain      (char_out.src)
    );

    // Two-stage synchronisers for pins; the host clock gets a third stage for edges.
    // The host clock stages reset to its idle high level, so no false rise follows reset.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            {mode_s1_reg, mode_reg}                 <= 2'h0;
            {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= {3{`CID_SCLK_IDLE}};
            {ring_s1_reg, ring_s2_reg}              <= 2'h0;
            {hold_s1_reg, hold_s2_reg}              <= 2'h0;
        end
        else
        begin
            {mode_s1_reg, mode_reg}                 <= {MODE_SEL_IN, mode_s1_reg};
            {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= {SERIAL_SHIFT_CLOCK_IN, sclk_s1_reg,
                                                        sclk_s2_reg};
            {ring_s1_reg, ring_s2_reg}              <= {RING_SENSE_IN, ring_s1_reg};
            {hold_s1_reg, hold_s2_reg}              <= {RING_HOLD_TIMING_IN, hold_s1_reg};
        end
    end

    // Character assembler: eight bits, first bit in the low position.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            asm_reg      <= 8'h00;
            asm_cnt_reg  <= 4'h0;
            asm_full_reg <= 1'b0;
        end
        else
        begin
            if (char_in.ready)
                asm_full_reg <= 1'b0;
            if (bit_take)
            begin
                asm_reg     <= {FSK_BIT_IN, asm_reg[7:1]};
                asm_cnt_reg <= last_bit ? 4'h0 : asm_cnt_reg + 4'h1;
                if (last_bit && host_mode)
                    asm_full_reg <= 1'b1;
            end
        end
    end

    // Host shifter: holds a char until eight host clock rises have passed.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            shift_reg      <= 8'h00;
            shift_cnt_reg  <= 4'h0;
            shift_busy_reg <= 1'b0;
        end
        else if (load_char)
        begin
            shift_reg      <= char_out.data;
            shift_cnt_reg  <= 4'h0;
            shift_busy_reg <= 1'b1;
        end
        else if (shift_busy_reg && host_rise)
        begin
            shift_reg      <= {1'b0, shift_reg[7:1]};
            shift_cnt_reg  <= shift_cnt_reg + 4'h1;
            shift_busy_reg <= !is_last(shift_cnt_reg);
        end
    end

    // Device-paced clock: low for half a bit after each bit, then high.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            pace_reg     <= cid_pkg::CID_IDLE;
            half_cnt_reg <= '0;
            boundary_reg <= 1'b0;
        end
        else if (host_mode)
        begin
            pace_reg     <= cid_pkg::CID_IDLE;
            half_cnt_reg <= '0;
            boundary_reg <= 1'b0;
        end
        else if (bit_take)
        begin
            pace_reg     <= cid_pkg::CID_LOW;
            half_cnt_reg <= '0;
            boundary_reg <= last_bit;
        end
        else
        begin
            half_cnt_reg <= half_done ? '0 : half_cnt_reg + 1'b1;
            unique case (pace_reg)
                cid_pkg::CID_IDLE: half_cnt_reg <= '0;
                cid_pkg::CID_LOW:
                    if (half_done)
                        pace_reg <= boundary_reg ? cid_pkg::CID_MARK : cid_pkg::CID_HIGH;
                cid_pkg::CID_MARK:
                    if (half_done)
                        pace_reg <= cid_pkg::CID_HIGH;
                cid_pkg::CID_HIGH: half_cnt_reg <= '0;
            endcase
        end
    end

    // Registered pin outputs for data, clock, ready and carrier.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            sclk_out_reg  <= 1'b1;
            data_reg      <= `CID_MARK;
            ready_n_reg   <= 1'b1;
            carrier_n_reg <= 1'b1;
        end
        else
        begin
            sclk_out_reg  <= (pace_reg != cid_pkg::CID_LOW) && !bit_take;
            carrier_n_reg <= !FSK_CARRIER_IN;
            if (host_mode)
            begin
                data_reg    <= shift_busy_reg ? shift_reg[0] : `CID_MARK;
                ready_n_reg <= !shift_busy_reg;
            end
            else
            begin
                if (bit_take)
                    data_reg <= FSK_BIT_IN ? `CID_MARK : `CID_SPACE;
                ready_n_reg <= (pace_reg != cid_pkg::CID_MARK);
            end
        end
    end

    // Ring indication: low on sense, released once the RC pin charges high.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            ring_n_reg <= 1'b1;
        else if (ring_s2_reg)
            ring_n_reg <= 1'b0;
        else if (hold_s2_reg)
            ring_n_reg <= 1'b1;
    end
endmodule
`default_nettype wire

// >>> testbench/cid_out_checker.sv
// Concurrent checks on the pins of the caller ID digital output block.
`default_nettype none
module cid_out_checker
#(
    parameter logic [15:0] HALF_BIT_CYCLES = 16'h0008
)
(
    // Clock and reset.
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    // Mode, demodulator and ring inputs.
    input wire logic MODE_SEL_IN,
    input wire logic FSK_CARRIER_IN,
    input wire logic FSK_BIT_IN,
    input wire logic FSK_BIT_VALID_IN,
    input wire logic RING_SENSE_IN,
    input wire logic RING_HOLD_TIMING_IN,
    // Block outputs.
    input wire logic FSK_BIT_READY_OUT,
    input wire logic SERIAL_SHIFT_CLOCK_OUT,
    input wire logic SERIAL_SHIFT_CLOCK_OE_OUT,
    input wire logic SERIAL_DATA_OUT,
    input wire logic CHAR_READY_N_OUT,
    input wire logic CARRIER_PRESENT_N_OUT,
    input wire logic RING_HOLD_TIMING_OE_OUT,
    input wire logic RING_DETECTED_N_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] low_cnt_reg;
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // Counts how long the paced clock has been low.
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
            low_cnt_reg <= 16'h0000;
        else
            low_cnt_reg <= SERIAL_SHIFT_CLOCK_OUT ? 16'h0000 : low_cnt_reg + 16'h0001;
    end
    // A bit accepted in device-paced mode, and a quiet ring input.
    sequence s_bit_taken;
        FSK_BIT_VALID_IN && FSK_BIT_READY_OUT && SERIAL_SHIFT_CLOCK_OE_OUT;
    endsequence
    sequence s_ring_quiet;
        !RING_SENSE_IN [*4];
    endsequence
    // Pin relations over time.
    chk_carrier_follow: assert property (1'b1 |=>
        CARRIER_PRESENT_N_OUT == !$past(FSK_CARRIER_IN)) else $error("carrier output wrong");
    chk_mode_select: assert property ($past(MODE_SEL_IN, 3) == MODE_SEL_IN
        && $past(MODE_SEL_IN, 2) == MODE_SEL_IN |-> SERIAL_SHIFT_CLOCK_OE_OUT == !MODE_SEL_IN)
        else $error("clock direction wrong");
    chk_ring_assert: assert property (RING_SENSE_IN [*4] |-> !RING_DETECTED_N_OUT)
        else $error("ring output not low");
    chk_ring_hold: assert property ((!RING_HOLD_TIMING_IN) [*3] ##0 !RING_DETECTED_N_OUT
        |=> !RING_DETECTED_N_OUT) else $error("ring output released early");
    chk_ring_release: assert property (s_ring_quiet ##0 $rose(RING_HOLD_TIMING_IN)
        |-> ##[1:4] RING_DETECTED_N_OUT) else $error("ring output not released");
    chk_host_idle: assert property (!SERIAL_SHIFT_CLOCK_OE_OUT && CHAR_READY_N_OUT
        |-> SERIAL_DATA_OUT) else $error("idle data not mark");
    chk_paced_bit: assert property (s_bit_taken |=> !SERIAL_SHIFT_CLOCK_OUT
        && SERIAL_DATA_OUT == $past(FSK_BIT_IN)) else $error("paced bit wrong");
    chk_paced_half: assert property ($rose(SERIAL_SHIFT_CLOCK_OUT)
        && SERIAL_SHIFT_CLOCK_OE_OUT |-> low_cnt_reg >= HALF_BIT_CYCLES)
        else $error("paced clock low too short");
endmodule
`default_nettype wire

// >>> testbench/cid_host_model.sv
// Host controller model that clocks characters out in host-clocked mode.
`default_nettype none
module cid_host_model
(
    // Clock and device pins.
    input  wire logic       MCLK_IN,
    input  wire logic       ready_n_in,
    input  wire logic       data_in,
    input  wire logic       slow_in,
    // Host clock pin and received characters.
    output logic            clk_out,
    output logic [7:0]      char_out,
    output logic            strobe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Waits for a waiting character, then gives eight 400 ns clocks; idle between frames.
    initial
    begin
        clk_out = 1'b1;
        char_out = 8'h00;
        strobe_out = 1'b0;
        forever
        begin
            @(posedge MCLK_IN);
            #5 strobe_out = 1'b0;
            if (ready_n_in === 1'b0)
            begin
                if (slow_in)
                    repeat (40) @(posedge MCLK_IN);
                for (int k = 0; k < 8; k++)
                begin
                    #5 clk_out = 1'b0;
                    repeat (4) @(posedge MCLK_IN);
                    #5 char_out[k] = data_in; // Bits arrive first bit first.
                    clk_out = 1'b1; // The rising edge asks for the next bit.
                    repeat (4) @(posedge MCLK_IN);
                end
                repeat (4) @(posedge MCLK_IN);
                #5 strobe_out = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/cid_out_tb.sv
// Self-checking bench for the caller ID digital output block.
`default_nettype none
module cid_out_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] HB = 16'h0008;
    logic clk, rst, mode, bit_v, bit_d, car, sense, slow, refused, rdy, host_clk, stb;
    logic sclk_o, sclk_oe, sdata, rdy_n, car_n, rc_oe, ring_n;
    logic [7:0] rx, rc_cnt;
    logic [16:0] seed;
    int mismatches, n_tests;
    logic [7:0] exp_q[$];
    wire logic sclk_pin = sclk_oe ? sclk_o : host_clk;
    wire logic rc_pin = !rc_oe && (rc_cnt > 8'h1e);
    cid_out #(.HALF_BIT_CYCLES(HB)) uut (.MCLK_IN(clk), .SYS_RST_IN(rst), .MODE_SEL_IN(mode),
        .FSK_BIT_IN(bit_d), .FSK_BIT_VALID_IN(bit_v), .FSK_CARRIER_IN(car),
        .FSK_BIT_READY_OUT(rdy), .SERIAL_SHIFT_CLOCK_IN(sclk_pin),
        .SERIAL_SHIFT_CLOCK_OUT(sclk_o), .SERIAL_SHIFT_CLOCK_OE_OUT(sclk_oe),
        .SERIAL_DATA_OUT(sdata), .CHAR_READY_N_OUT(rdy_n), .CARRIER_PRESENT_N_OUT(car_n),
        .RING_SENSE_IN(sense), .RING_HOLD_TIMING_IN(rc_pin),
        .RING_HOLD_TIMING_OE_OUT(rc_oe), .RING_DETECTED_N_OUT(ring_n));
    cid_host_model host (.MCLK_IN(clk), .ready_n_in(rdy_n | sclk_oe), .data_in(sdata),
        .slow_in(slow), .clk_out(host_clk), .char_out(rx), .strobe_out(stb));
    // Clock of 50 ns period.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Charges the ring capacitor while released and compares each character received.
    always @(posedge clk)
    begin
        rc_cnt <= rc_oe ? 8'h00 : rc_cnt + {7'h00, rc_cnt != 8'hff};
        if (stb === 1'b1)
            check_char(rx, exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx);
    end
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic check_char(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        check_char({7'h00, got}, {7'h00, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    // Offers one bit and holds it until accepted; notes any refusal.
    task automatic send_bit(input logic b);
        int i;
        i = 0;
        bit_v = 1'b1;
        bit_d = b;
        #1;
        while (rdy !== 1'b1 && i < 5000)
        begin
            refused = 1'b1;
            tick(1);
            #1;
            i++;
        end
        if (i == 5000)
        begin
            mismatches++;
            complete_run();
        end
        else
            tick(1);
    endtask
    task automatic send_char(input logic [7:0] c, input int gap);
        for (int k = 0; k < 8; k++)
        begin
            send_bit(c[k]);
            if (gap != 0)
            begin
                bit_v = 1'b0;
                tick(int'(HB) + 4);
                check_flag(rdy_n, k != 7);
                tick(gap - int'(HB) - 4);
                check_flag(sdata, c[k]);
                check_flag(sclk_o, 1'b1);
            end
        end
    endtask
    task automatic complete_run();
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence: host-clocked traffic with stalls, device-paced traffic, then ringing.
    initial
    begin
        int i;
        rst = 1'b1;
        {mode, bit_v, car, sense, slow, refused} = 6'h00;
        bit_d = 1'b1;
        rc_cnt = 8'hff;
        seed = 17'h17ba5;
        mismatches = 0;
        n_tests = 0;
        tick(8);
        rst = 1'b0;
        mode = 1'b1;
        car = 1'b1;
        tick(4);
        check_flag(sclk_oe, 1'b0);
        check_flag(car_n, 1'b0);
        for (int j = 0; j < 8; j++)
        begin
            seed = lfsr(seed);
            slow = (j > 1);
            exp_q.push_back(seed[7:0]);
            send_char(seed[7:0], 0);
        end
        bit_v = 1'b0;
        check_flag(refused, 1'b1);
        for (i = 0; i < 20000 && exp_q.size() != 0; i++)
            tick(1);
        tick(12);
        check_flag(exp_q.size() == 0, 1'b1);
        check_flag(rdy_n, 1'b1);
        mode = 1'b0;
        car = 1'b0;
        tick(4);
        check_flag(sclk_oe, 1'b1);
        check_flag(car_n, 1'b1);
        seed = lfsr(seed);
        send_char(seed[7:0], 24);
        sense = 1'b1;
        tick(10);
        check_flag(ring_n, 1'b0);
        check_flag(rc_oe, 1'b1);
        sense = 1'b0;
        tick(20);
        check_flag(ring_n, 1'b0);
        tick(25);
        check_flag(ring_n, 1'b1);
        complete_run();
    end
endmodule
bind cid_out cid_out_checker #(.HALF_BIT_CYCLES(HALF_BIT_CYCLES)) chk
(
    .MCLK_IN                   (MCLK_IN),
    .SYS_RST_IN                (SYS_RST_IN),
    .MODE_SEL_IN               (MODE_SEL_IN),
    .FSK_CARRIER_IN            (FSK_CARRIER_IN),
    .FSK_BIT_IN                (FSK_BIT_IN),
    .FSK_BIT_VALID_IN          (FSK_BIT_VALID_IN),
    .RING_SENSE_IN             (RING_SENSE_IN),
    .RING_HOLD_TIMING_IN       (RING_HOLD_TIMING_IN),
    .FSK_BIT_READY_OUT         (FSK_BIT_READY_OUT),
    .SERIAL_SHIFT_CLOCK_OUT    (SERIAL_SHIFT_CLOCK_OUT),
    .SERIAL_SHIFT_CLOCK_OE_OUT (SERIAL_SHIFT_CLOCK_OE_OUT),
    .SERIAL_DATA_OUT           (SERIAL_DATA_OUT),
    .CHAR_READY_N_OUT          (CHAR_READY_N_OUT),
    .CARRIER_PRESENT_N_OUT     (CARRIER_PRESENT_N_OUT),
    .RING_HOLD_TIMING_OE_OUT   (RING_HOLD_TIMING_OE_OUT),
    .RING_DETECTED_N_OUT       (RING_DETECTED_N_OUT)
);
`default_nettype wire
